// File: hdl/ett_pkg.sv
// Shared constants and types for the edge trigger unit.
// Assumes a single 25 MHz core clock.
package ett_pkg;
  // ==========================================================
  // Sources
  localparam int NCH = 16;
  localparam int NSRC = 18;
  localparam int SRC_W = 5;
  localparam logic [4:0] SRC_AUX = 5'h10;
  localparam logic [4:0] SRC_MAINS = 5'h11;
  localparam int AMP_W = 8;
  localparam logic [7:0] THR_RST = 8'h80;
  // ==========================================================
  // Holdoff and timing
  localparam int PCT_W = 7;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [6:0] PCT_RST = 7'h00;
  localparam int CLK_NS = 40;
  localparam int HO_MIN_NS = 250;
  localparam int HO_MAX_NS = 12000000;
  localparam int HO_MIN_CYC = (HO_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int HO_MAX_CYC = HO_MAX_NS / CLK_NS;
  localparam int AUTO_BASE_NS = 100000;
  localparam int AUTO_BASE_CYC = AUTO_BASE_NS / CLK_NS;
  localparam int CNT_W = 32;
  localparam int TB_W = 4;
  // ==========================================================
  // Enumerations
  typedef enum logic [0:0] {
    SLOPE_RISE = 1'b0,
    SLOPE_FALL = 1'b1
  } ett_slope_t;
  typedef enum logic [0:0] {
    MODE_AUTO = 1'b0,
    MODE_NORMAL = 1'b1
  } ett_mode_t;
  typedef enum logic [0:0] {
    ST_HOLDOFF = 1'b0,
    ST_ARMED = 1'b1
  } ett_state_t;
endpackage

// File: hdl/ett_thr_mem.sv
// Per-source threshold store, one write port, two read ports.
// Assumes writes and addresses come from the core clock domain.
`timescale 1ns/1ps
module ett_thr_mem #(
  parameter int DEPTH = ett_pkg::NSRC,
  parameter int AW = ett_pkg::SRC_W,
  parameter int DW = ett_pkg::AMP_W
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_a_addr_in,
  input wire logic [AW-1:0] rd_b_addr_in,
  output logic [DW-1:0] rd_a_data_out,
  output logic [DW-1:0] rd_b_data_out
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rda;
    logic [DW-1:0] rdb;
  } ett_mem_st_t;

  ett_mem_st_t q;
  ett_mem_st_t d;

  // ==========================================================
  // Next state
  always_comb
  begin
    d = q;
    if (wr_en_in && (int'(wr_addr_in) < DEPTH))
    begin
      d.mem[wr_addr_in] = wr_data_in;
    end
    d.rda = (int'(rd_a_addr_in) < DEPTH) ? q.mem[rd_a_addr_in] : '0;
    d.rdb = (int'(rd_b_addr_in) < DEPTH) ? q.mem[rd_b_addr_in] : '0;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q.mem <= {DEPTH{DW'(ett_pkg::THR_RST)}};
      q.rda <= DW'(ett_pkg::THR_RST);
      q.rdb <= DW'(ett_pkg::THR_RST);
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_a_data_out = q.rda;
  assign rd_b_data_out = q.rdb;
endmodule

// File: hdl/ett_top.sv
// Edge trigger unit: main and delayed edge trigger paths.
// Assumes amplitudes arrive asynchronously; controls are core-clocked.
`timescale 1ns/1ps
module ett_top #(
  parameter int HO_MAX_CYC = ett_pkg::HO_MAX_CYC,
  parameter int AUTO_BASE_CYC = ett_pkg::AUTO_BASE_CYC
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [ett_pkg::NCH-1:0][ett_pkg::AMP_W-1:0] input_channel_sources_in,
  input wire logic [ett_pkg::AMP_W-1:0] aux_trig_level_in,
  input wire logic [ett_pkg::AMP_W-1:0] mains_frequency_source_in,
  input wire logic [ett_pkg::SRC_W-1:0] main_src_sel_in,
  input wire ett_pkg::ett_slope_t main_slope_in,
  input wire ett_pkg::ett_mode_t main_mode_in,
  input wire logic [ett_pkg::SRC_W-1:0] dly_src_sel_in,
  input wire ett_pkg::ett_slope_t dly_slope_in,
  input wire logic dly_arm_in,
  input wire logic [ett_pkg::TB_W-1:0] main_timebase_in,
  input wire logic main_tb_change_in,
  input wire logic holdoff_wr_in,
  input wire logic [ett_pkg::PCT_W-1:0] holdoff_pct_in,
  input wire logic thr_wr_in,
  input wire logic [ett_pkg::SRC_W-1:0] thr_wr_src_in,
  input wire logic [ett_pkg::AMP_W-1:0] thr_wr_data_in,
  input wire logic threshold_midpoint_command_in,
  output logic main_trig_out,
  output logic acq_start_out,
  output logic auto_acq_out,
  output logic dly_trig_out,
  output logic armed_out,
  output logic [ett_pkg::PCT_W-1:0] holdoff_pct_out
);
  localparam int NS = ett_pkg::NSRC;
  localparam int AW = ett_pkg::AMP_W;
  localparam int CW = ett_pkg::CNT_W;
  localparam logic [CW-1:0] HO_MIN = CW'(ett_pkg::HO_MIN_CYC);
  localparam logic [CW-1:0] HO_SPAN = CW'(HO_MAX_CYC - ett_pkg::HO_MIN_CYC);

  typedef struct packed {
    logic [NS-1:0][AW-1:0] s1;
    logic [NS-1:0][AW-1:0] s2;
    ett_pkg::ett_state_t st;
    logic [CW-1:0] ho_cnt;
    logic [CW-1:0] auto_cnt;
    logic [CW-1:0] ho_len;
    logic [ett_pkg::PCT_W-1:0] pct;
    logic m_above;
    logic m_prime;
    logic d_above;
    logic d_prime;
    logic [AW-1:0] pk_max;
    logic [AW-1:0] pk_min;
    logic [ett_pkg::SRC_W-1:0] pk_src;
    logic main_trig;
    logic acq;
    logic auto_acq;
    logic dly_trig;
  } ett_st_t;

  ett_st_t q;
  ett_st_t d;
  logic [AW-1:0] m_thr;
  logic [AW-1:0] d_thr;
  logic [AW-1:0] m_amp;
  logic [AW-1:0] d_amp;
  logic m_now;
  logic d_now;
  logic m_fire;
  logic d_fire;
  logic auto_fire;
  logic [CW-1:0] auto_lim;
  logic [AW-1:0] mid;
  logic mem_we;
  logic [ett_pkg::SRC_W-1:0] mem_wa;
  logic [AW-1:0] mem_wd;
  logic [CW+ett_pkg::PCT_W-1:0] prod;

  // ==========================================================
  // Shared threshold store
  ett_thr_mem #(
    .DEPTH(NS),
    .AW(ett_pkg::SRC_W),
    .DW(AW)
  ) u_thr (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_wa),
    .wr_data_in(mem_wd),
    .rd_a_addr_in(main_src_sel_in),
    .rd_b_addr_in(dly_src_sel_in),
    .rd_a_data_out(m_thr),
    .rd_b_data_out(d_thr)
  );

  // ==========================================================
  // Source selection and crossing detection
  always_comb
  begin
    m_amp = (int'(main_src_sel_in) < NS) ? q.s2[main_src_sel_in] : '0;
    d_amp = (int'(dly_src_sel_in) < NS) ? q.s2[dly_src_sel_in] : '0;
    m_now = (m_amp >= m_thr);
    d_now = (d_amp >= d_thr);
    // Two consecutive samples, one on either side of the threshold, mark the crossing
    m_fire = (q.st == ett_pkg::ST_ARMED) && q.m_prime
      && (m_now != q.m_above)
      && (m_now == (main_slope_in == ett_pkg::SLOPE_RISE));
    d_fire = dly_arm_in && q.d_prime && (d_now != q.d_above)
      && (d_now == (dly_slope_in == ett_pkg::SLOPE_RISE));
    auto_lim = CW'(AUTO_BASE_CYC) << main_timebase_in;
    auto_fire = (q.st == ett_pkg::ST_ARMED) && !m_fire
      && (main_mode_in == ett_pkg::MODE_AUTO)
      && (q.auto_cnt >= auto_lim - 1'b1);
    mid = AW'(({1'b0, q.pk_max} + {1'b0, q.pk_min}) >> 1);
    mem_we = threshold_midpoint_command_in || thr_wr_in;
    mem_wa = threshold_midpoint_command_in ? main_src_sel_in : thr_wr_src_in;
    mem_wd = threshold_midpoint_command_in ? mid : thr_wr_data_in;
    prod = HO_SPAN * q.pct;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    d = q;
    d.s1 = {mains_frequency_source_in, aux_trig_level_in,
      input_channel_sources_in};
    d.s2 = q.s1;
    d.main_trig = 1'b0;
    d.acq = 1'b0;
    d.auto_acq = 1'b0;
    d.dly_trig = d_fire;
    // Holdoff percent; timebase change wins over a write
    if (main_tb_change_in)
    begin
      d.pct = ett_pkg::PCT_RST;
    end
    else if (holdoff_wr_in)
    begin
      d.pct = (holdoff_pct_in > ett_pkg::PCT_MAX) ? ett_pkg::PCT_MAX
        : holdoff_pct_in;
    end
    d.ho_len = HO_MIN + CW'(prod / 100);
    // Peak tracker for the midpoint level
    if (q.pk_src != main_src_sel_in)
    begin
      d.pk_src = main_src_sel_in;
      d.pk_max = m_amp;
      d.pk_min = m_amp;
    end
    else
    begin
      if (m_amp > q.pk_max)
      begin
        d.pk_max = m_amp;
      end
      if (m_amp < q.pk_min)
      begin
        d.pk_min = m_amp;
      end
    end
    d.m_above = m_now;
    d.d_above = d_now;
    d.d_prime = dly_arm_in;
    unique case (q.st)
      ett_pkg::ST_HOLDOFF:
      begin
        d.m_prime = 1'b0;
        d.auto_cnt = '0;
        if (q.ho_cnt <= 1)
        begin
          d.st = ett_pkg::ST_ARMED;
        end
        else
        begin
          d.ho_cnt = q.ho_cnt - 1'b1;
        end
      end
      ett_pkg::ST_ARMED:
      begin
        d.m_prime = 1'b1;
        d.auto_cnt = q.auto_cnt + 1'b1;
        if (m_fire || auto_fire)
        begin
          d.main_trig = m_fire;
          d.acq = 1'b1;
          d.auto_acq = auto_fire;
          d.st = ett_pkg::ST_HOLDOFF;
          d.ho_cnt = q.ho_len;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q <= '0;
      q.st <= ett_pkg::ST_HOLDOFF;
      q.ho_cnt <= HO_MIN;
      q.ho_len <= HO_MIN;
      q.pct <= ett_pkg::PCT_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign main_trig_out = q.main_trig;
  assign acq_start_out = q.acq;
  assign auto_acq_out = q.auto_acq;
  assign dly_trig_out = q.dly_trig;
  assign armed_out = (q.st == ett_pkg::ST_ARMED);
  assign holdoff_pct_out = q.pct;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  logic [CW-1:0] ho_seen;
  logic [CW-1:0] ho_want;
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ho_seen <= '0;
      ho_want <= HO_MIN;
    end
    else
    begin
      ho_seen <= (q.st == ett_pkg::ST_HOLDOFF) ? ho_seen + 1'b1 : '0;
      ho_want <= armed_out ? q.ho_len : ho_want;
    end
  end

  sequence s_mid_cmd;
    threshold_midpoint_command_in && !main_tb_change_in;
  endsequence

  chk_no_fire_holdoff: assert property (
    main_trig_out |-> $past(armed_out))
    else $error("trigger left holdoff too early");
  chk_src_aux_path: assert property (
    (main_src_sel_in == ett_pkg::SRC_AUX)
      |-> (m_amp == $past(aux_trig_level_in, 2)))
    else $error("auxiliary source not selected");
  chk_cross_edge: assert property (
    main_trig_out |-> ($past(m_now) != $past(q.m_above)))
    else $error("trigger without a crossing");
  chk_slope_dir: assert property (
    main_trig_out |-> ($past(m_now)
      == ($past(main_slope_in) == ett_pkg::SLOPE_RISE)))
    else $error("trigger on the wrong slope");
  chk_auto_only: assert property (
    auto_acq_out |-> ($past(main_mode_in) == ett_pkg::MODE_AUTO)
      && acq_start_out)
    else $error("auto acquisition outside auto mode");
  chk_normal_trig: assert property (
    (acq_start_out && !main_trig_out) |-> auto_acq_out
      && ($past(main_mode_in) == ett_pkg::MODE_AUTO))
    else $error("acquisition without cause");
  chk_pct_clear: assert property (
    main_tb_change_in |=> (holdoff_pct_out == ett_pkg::PCT_RST)
      ##1 (q.ho_len == HO_MIN))
    else $error("holdoff not cleared on timebase change");
  chk_mid_load: assert property (
    s_mid_cmd ##1 (main_src_sel_in == $past(main_src_sel_in))
      |=> (m_thr == $past(mid, 2)))
    else $error("midpoint not loaded");
  chk_ho_length: assert property (
    $rose(armed_out) |-> (ho_seen == ho_want))
    else $error("holdoff length differs from setting");
endmodule

// File: verification/ett_chan_model.sv
// Source model: sixteen channel levels, auxiliary and mains levels.
// Assumes the bench calls set_amp just after a falling clock edge.
`timescale 1ns/1ps
module ett_chan_model (
  output logic [ett_pkg::NCH-1:0][ett_pkg::AMP_W-1:0] chan_out,
  output logic [ett_pkg::AMP_W-1:0] aux_out,
  output logic [ett_pkg::AMP_W-1:0] mains_out
);
  // ==========================================================
  // Levels
  initial
  begin
    chan_out = '0;
    aux_out = 8'h00;
    mains_out = 8'h00;
  end
  // Index 16 is auxiliary, 17 mains
  task automatic set_amp(input int idx, input logic [7:0] v);
    begin
      if (idx < 16)
        chan_out[idx] = v;
      else if (idx == 16)
        aux_out = v;
      else
        mains_out = v;
    end
  endtask
endmodule

// File: verification/test_ett_top.sv
// Self-checking bench for the edge trigger unit.
// Assumes shortened holdoff and auto counts; inputs at falling edge.
`timescale 1ns/1ps
module test_ett_top;
  localparam int HOMAX = 40;
  localparam int ABASE = 8;
  localparam int HMIN = ett_pkg::HO_MIN_CYC;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] src = 5'h00;
  ett_pkg::ett_slope_t slope = ett_pkg::SLOPE_RISE;
  ett_pkg::ett_mode_t mode = ett_pkg::MODE_NORMAL;
  logic [4:0] dsrc = 5'h00;
  ett_pkg::ett_slope_t dslope = ett_pkg::SLOPE_RISE;
  logic darm = 1'b0;
  logic [3:0] tb = 4'h0;
  logic tbchg = 1'b0;
  logic howr = 1'b0;
  logic [6:0] hopct = 7'h00;
  logic thrwr = 1'b0;
  logic [4:0] thrsrc = 5'h00;
  logic [7:0] thrdat = 8'h00;
  logic mid = 1'b0;
  logic [15:0][7:0] chan;
  logic [7:0] aux;
  logic [7:0] mains;
  wire logic [3:0] sig;
  logic [6:0] pct;
  logic auto_acq;
  int failures = 0;
  int check_count = 0;
  int n;
  // ==========================================================
  // Clock, model and design
  initial
  begin
    forever #20 clk = ~clk;
  end
  ett_chan_model m_src (.chan_out(chan), .aux_out(aux), .mains_out(mains));
  ett_top #(.HO_MAX_CYC(HOMAX), .AUTO_BASE_CYC(ABASE)) i_dut (
    .core_clk_in(clk),
    .arst_n_in(arst_n),
    .input_channel_sources_in(chan),
    .aux_trig_level_in(aux),
    .mains_frequency_source_in(mains),
    .main_src_sel_in(src),
    .main_slope_in(slope),
    .main_mode_in(mode),
    .dly_src_sel_in(dsrc),
    .dly_slope_in(dslope),
    .dly_arm_in(darm),
    .main_timebase_in(tb),
    .main_tb_change_in(tbchg),
    .holdoff_wr_in(howr),
    .holdoff_pct_in(hopct),
    .thr_wr_in(thrwr),
    .thr_wr_src_in(thrsrc),
    .thr_wr_data_in(thrdat),
    .threshold_midpoint_command_in(mid),
    .main_trig_out(sig[0]),
    .acq_start_out(sig[2]),
    .auto_acq_out(auto_acq),
    .dly_trig_out(sig[3]),
    .armed_out(sig[1]),
    .holdoff_pct_out(pct)
  );
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      check_count++;
      if (got !== exp)
      begin
        failures++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Cycles until sig[w] is high; lim when never
  task automatic wait_sig(input int w, input int lim, output int k);
    begin
      k = 0;
      while (k < lim && sig[w] !== 1'b1)
      begin
        tick(1);
        k++;
      end
    end
  endtask
  task automatic fire(input int s, output int k);
    begin
      m_src.set_amp(s, 8'h10);
      tick(4);
      wait_sig(1, 90, k);
      m_src.set_amp(s, 8'hf0);
      wait_sig(0, 12, k);
      chk(k, 3);
      wait_sig(1, 90, k);
    end
  endtask
  task automatic set_ho(input logic [6:0] p, input logic w, input logic c);
    begin
      hopct = p;
      howr = w;
      tbchg = c;
      tick(1);
      howr = 1'b0;
      tbchg = 1'b0;
      tick(2);
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_sources;
    logic [7:0] a;
    begin
      for (int s = 0; s < 18; s++)
      begin
        src = 5'(s);
        slope = s[0] ? ett_pkg::SLOPE_FALL : ett_pkg::SLOPE_RISE;
        a = s[0] ? 8'hf0 : 8'h10;
        m_src.set_amp(s, ~a);
        tick(4);
        wait_sig(1, 90, n);
        m_src.set_amp(s, a);
        m_src.set_amp((s + 5) % 18, 8'hff);
        wait_sig(0, 12, n);
        chk(n, 12);
        m_src.set_amp(s, ~a);
        wait_sig(0, 12, n);
        chk(n, 3);
      end
      $display("t_sources done");
    end
  endtask
  task automatic t_holdoff;
    begin
      src = 5'h00;
      slope = ett_pkg::SLOPE_RISE;
      set_ho(7'h78, 1'b1, 1'b0);
      chk(pct, 7'h64);
      fire(0, n);
      chk(n, HOMAX);
      set_ho(7'h32, 1'b1, 1'b1);
      chk(pct, 7'h00);
      set_ho(7'h32, 1'b1, 1'b0);
      dslope = ett_pkg::SLOPE_FALL;
      tick(2);
      chk(pct, 7'h32);
      fire(0, n);
      chk(n, HMIN + (HOMAX - HMIN) * 50 / 100);
      set_ho(7'h32, 1'b0, 1'b1);
      chk(pct, 7'h00);
      fire(0, n);
      chk(n, HMIN);
      $display("t_holdoff done");
    end
  endtask
  task automatic t_auto;
    begin
      mode = ett_pkg::MODE_AUTO;
      for (int k = 0; k < 3; k++)
      begin
        tb = 4'(k);
        fire(0, n);
        wait_sig(2, 400, n);
        chk(n, ABASE << k);
        chk(auto_acq, 1'b1);
      end
      mode = ett_pkg::MODE_NORMAL;
      fire(0, n);
      wait_sig(2, 300, n);
      chk(n, 300);
      $display("t_auto done");
    end
  endtask
  task automatic t_thr;
    begin
      src = 5'h03;
      dsrc = 5'h03;
      dslope = ett_pkg::SLOPE_FALL;
      darm = 1'b1;
      thrsrc = 5'h03;
      thrdat = 8'h40;
      thrwr = 1'b1;
      tick(1);
      thrwr = 1'b0;
      m_src.set_amp(3, 8'h30);
      tick(4);
      wait_sig(1, 90, n);
      m_src.set_amp(3, 8'h50);
      wait_sig(0, 12, n);
      chk(n, 3);
      m_src.set_amp(3, 8'h30);
      wait_sig(3, 12, n);
      chk(n, 3);
      tick(1);
      mode = ett_pkg::MODE_AUTO;
      wait_sig(3, 40, n);
      chk(n, 40);
      mode = ett_pkg::MODE_NORMAL;
      darm = 1'b0;
      m_src.set_amp(5, 8'h20);
      tick(4);
      src = 5'h05;
      tick(3);
      m_src.set_amp(5, 8'ha0);
      tick(4);
      m_src.set_amp(5, 8'h20);
      tick(4);
      mid = 1'b1;
      tick(1);
      mid = 1'b0;
      tick(3);
      wait_sig(1, 90, n);
      m_src.set_amp(5, 8'h5c);
      wait_sig(0, 12, n);
      chk(n, 12);
      m_src.set_amp(5, 8'h64);
      wait_sig(0, 12, n);
      chk(n, 3);
      $display("t_thr done");
    end
  endtask
  task automatic t_reset;
    begin
      m_src.set_amp(0, 8'hc0);
      wait_sig(1, 20, n);
      chk(n, HMIN);
      wait_sig(0, 13, n);
      chk(n, 13);
      $display("t_reset done");
    end
  endtask
  task automatic end_of_test;
    begin
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial
  begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_sources();
    t_holdoff();
    t_auto();
    t_thr();
    end_of_test();
  end
  initial
  begin
    #(40 * 20000);
    failures++;
    end_of_test();
  end
endmodule
